// [rtl/core_mode_ctrl.sv]
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
// Core operating mode control register with an AHB-Lite slave port
module core_mode_ctrl #(
	parameter int STOP_LONG_CYCLES = core_mode_pkg::STOP_LONG_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] mode_pins,
	input wire logic stack_underflow,
	input wire logic stack_overflow,
	input wire logic stack_wrap,
	input wire logic stop_exit_req,
	input wire logic transfer_ack,
	input wire logic bus_grant,
	input wire logic core_req,
	input wire logic dma_req,
	input wire logic [1:0] core_priority_field,
	input wire logic [1:0] dma_chan_prio,
	output logic [3:0] chip_mode,
	output logic ext_bus_off,
	output logic stop_exit_busy,
	output logic stop_exit_done,
	output logic memory_switch_en,
	output logic dma_wins,
	output logic cache_burst_en,
	output logic transfer_ack_used,
	output logic bus_grant_used,
	output logic bus_release_slow,
	output logic attr_prio_off,
	output logic addr_trace_en,
	output logic stack_ext_y,
	output logic stack_ext_en,
	output logic irq
);
	logic [23:0] mode_q;
	logic [23:0] mode_d;
	logic [3:0] istat_q;
	logic [3:0] istat_d;
	logic [3:0] imask_q;
	logic [3:0] imask_d;
	logic [3:0] events;
	logic mode_loaded_q;
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic take;
	logic rd_take;
	logic wr_mode;
	logic [31:0] rdata_d;
	logic [1:0] sync_vec;
	logic rr_q;
	logic stop_busy_w;
	logic stop_done_w;

	// An address phase is taken only when the bus is ready
	assign take = hsel && htrans[1] && hready;
	assign rd_take = take && !hwrite;
	assign wr_mode = wr_pend_q && (addr_q == core_mode_pkg::ADDR_MODE);

	// Address phase capture; writes land in the following data phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			if (hready) begin
				wr_pend_q <= take && hwrite;
				addr_q <= haddr[7:0];
			end
		end
	end

	// Zero wait states and always OKAY; unmapped words read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Stack events count only while the extension is active
	// extension enable gates
	assign events[core_mode_pkg::IRQ_UNDERFLOW] = stack_underflow && mode_q[core_mode_pkg::B_STACK_EN];
	assign events[core_mode_pkg::IRQ_OVERFLOW] = stack_overflow && mode_q[core_mode_pkg::B_STACK_EN];
	assign events[core_mode_pkg::IRQ_WRAP] = stack_wrap && mode_q[core_mode_pkg::B_STACK_EN];
	assign events[core_mode_pkg::IRQ_STOP_DONE] = stop_done_w;

	// Mode register next value; a hardware flag set beats a software clear
	always_comb begin
		mode_d = mode_q;
		if (!mode_loaded_q) begin
			mode_d[core_mode_pkg::MODE_LSB +: core_mode_pkg::MODE_W] = mode_pins;
		end
		if (wr_mode) begin
			mode_d = hwdata[23:0] & core_mode_pkg::MODE_WMASK;
		end
		if (events[core_mode_pkg::IRQ_UNDERFLOW]) begin
			mode_d[core_mode_pkg::B_UNDERFLOW] = 1'b1;
		end
		if (events[core_mode_pkg::IRQ_OVERFLOW]) begin
			mode_d[core_mode_pkg::B_OVERFLOW] = 1'b1;
		end
		if (events[core_mode_pkg::IRQ_WRAP]) begin
			mode_d[core_mode_pkg::B_WRAP] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= core_mode_pkg::MODE_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Mode pins are caught on the first edge after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_loaded_q <= 1'b0;
		end else begin
			mode_loaded_q <= 1'b1;
		end
	end

	// Interrupt status clears on read, but an event that same cycle survives
	always_comb begin
		istat_d = istat_q;
		if (rd_take && (haddr[7:0] == core_mode_pkg::ADDR_ISTAT)) begin
			istat_d = core_mode_pkg::IRQ_RESET;
		end
		istat_d = istat_d | events;
		imask_d = imask_q;
		if (wr_pend_q && (addr_q == core_mode_pkg::ADDR_IMASK)) begin
			imask_d = hwdata[3:0];
		end
	end

	// Interrupt registers and the level output, registered from next values
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			istat_q <= core_mode_pkg::IRQ_RESET;
			imask_q <= core_mode_pkg::IRQ_RESET;
			irq <= 1'b0;
		end else begin
			istat_q <= istat_d;
			imask_q <= imask_d;
			irq <= |(istat_d & imask_d);
		end
	end

	// Read mux forwards a write still in its data phase
	always_comb begin
		rdata_d = 32'h00000000;
		case (haddr[7:0])
			core_mode_pkg::ADDR_MODE: rdata_d = {8'h00, mode_d};
			core_mode_pkg::ADDR_ISTAT: rdata_d = {28'h0000000, istat_q};
			core_mode_pkg::ADDR_IMASK: rdata_d = {28'h0000000, imask_d};
			core_mode_pkg::ADDR_STATE: rdata_d = {29'h00000000, rr_q, dma_wins, stop_busy_w};
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Read data is set up for the data phase that follows
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_take) begin
			hrdata <= rdata_d;
		end
	end

	// Mode register fields drive the core straight from the flops
	assign chip_mode = mode_q[core_mode_pkg::MODE_LSB +: core_mode_pkg::MODE_W];
	assign ext_bus_off = mode_q[core_mode_pkg::B_EXT_OFF];
	assign memory_switch_en = mode_q[core_mode_pkg::B_MEM_SWITCH];
	assign cache_burst_en = mode_q[core_mode_pkg::B_BURST];
	assign bus_release_slow = mode_q[core_mode_pkg::B_BUS_SLOW];
	assign attr_prio_off = mode_q[core_mode_pkg::B_ATTR_OFF];
	assign addr_trace_en = mode_q[core_mode_pkg::B_TRACE];
	assign stack_ext_y = mode_q[core_mode_pkg::B_STACK_Y];
	assign stack_ext_en = mode_q[core_mode_pkg::B_STACK_EN];
	assign stop_exit_busy = stop_busy_w;
	assign stop_exit_done = stop_done_w;

	stop_delay #(
		.LONG_CYCLES(STOP_LONG_CYCLES),
		.SHORT_CYCLES(core_mode_pkg::STOP_SHORT_CYCLES)
	) u_stop_delay (
		.clk(clk),
		.resetn(resetn),
		.start(stop_exit_req),
		.short_sel(mode_q[core_mode_pkg::B_STOP_SHORT]),
		.busy(stop_busy_w),
		.done(stop_done_w)
	);

	// Both bus inputs share one synchroniser; the bits pick the path
	sync2 #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d({bus_grant, transfer_ack}),
		.q(sync_vec)
	);

	// Synchronising adds two cycles of latency, the price of safety
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			transfer_ack_used <= 1'b0;
			bus_grant_used <= 1'b0;
		end else begin
			transfer_ack_used <= mode_q[core_mode_pkg::B_ACK_SYNC] ? sync_vec[0] : transfer_ack;
			bus_grant_used <= mode_q[core_mode_pkg::B_ARB_SYNC] ? sync_vec[1] : bus_grant;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dma_wins <= 1'b0;
			rr_q <= 1'b0;
		end else begin
			case (mode_q[core_mode_pkg::B_CPD_LO +: 2])
				core_mode_pkg::CPD_COMPARE: dma_wins <= dma_req && (!core_req || (dma_chan_prio > core_priority_field));
				core_mode_pkg::CPD_DMA_HIGH: dma_wins <= dma_req;
				core_mode_pkg::CPD_EQUAL: dma_wins <= dma_req && (!core_req || rr_q);
				core_mode_pkg::CPD_DMA_LOW: dma_wins <= dma_req && !core_req;
				default: dma_wins <= 1'b0;
			endcase
			// Equal priority alternates whenever both contend
			if (dma_req && core_req) begin
				rr_q <= !rr_q;
			end
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_mode_pin_latch: assert property ($rose(mode_loaded_q) |-> chip_mode == $past(mode_pins))
		else $error("mode pins not latched at reset release");
	a_reset_pattern: assert property ($rose(mode_loaded_q) |-> mode_q[23:4] == core_mode_pkg::MODE_RESET[23:4])
		else $error("mode register reset pattern wrong");
	a_ext_bus_write: assert property (wr_mode |=> ext_bus_off == $past(hwdata[4]))
		else $error("external bus bit not taken from write");
	// Done rises at the sixteenth edge after the request, so it is first sampled one edge later
	a_stop_short: assert property ((stop_exit_req && !stop_busy_w && mode_q[6]) |-> ##17 stop_exit_done)
		else $error("short stop exit wait not 16 cycles");
	a_dma_high_prio: assert property ((mode_q[9:8] == 2'h1 && dma_req) |=> dma_wins)
		else $error("DMA lost while set higher");
	a_dma_low_prio: assert property ((mode_q[9:8] == 2'h3 && core_req) |=> !dma_wins)
		else $error("DMA won over core while set lower");
	a_ack_sync_path: assert property ($past(mode_q[11]) |-> transfer_ack_used == $past(transfer_ack, 3))
		else $error("synchronised acknowledge path wrong");
	a_ack_raw_path: assert property (!$past(mode_q[11]) |-> transfer_ack_used == $past(transfer_ack))
		else $error("raw acknowledge path wrong");
	a_arb_sync_path: assert property ($past(mode_q[13]) |-> bus_grant_used == $past(bus_grant, 3))
		else $error("synchronised grant path wrong");
	a_underflow_set: assert property ((stack_underflow && stack_ext_en) |=> mode_q[17] && istat_q[0])
		else $error("underflow flag not set");
	a_overflow_set: assert property ((stack_overflow && stack_ext_en) |=> mode_q[18])
		else $error("overflow flag not set");
	a_wrap_sticky: assert property ((mode_q[19] && !wr_mode) |=> mode_q[19])
		else $error("wrap flag dropped without write");
	a_irq_level: assert property (irq == |(istat_q & imask_q))
		else $error("interrupt level disagrees with status and mask");

	c_stop_exit: cover property (stop_exit_req && !stop_busy_w ##[1:20] stop_exit_done);
	c_wrap_irq: cover property (stack_wrap && stack_ext_en ##1 irq);
	c_mode_write: cover property (wr_mode ##1 ext_bus_off);
endmodule

// [shared/core_mode_pkg.sv]
package core_mode_pkg;
	// Register map, byte addresses on the word bus
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_ISTAT = 8'h04;
	localparam logic [7:0] ADDR_IMASK = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0C;
	// Mode register value after reset and bits that software may write
	localparam logic [23:0] MODE_RESET = 24'h000300;
	localparam logic [23:0] MODE_WMASK = 24'h1FFFDF;
	// Field positions of the mode register
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int B_EXT_OFF = 4;
	localparam int B_STOP_SHORT = 6;
	localparam int B_MEM_SWITCH = 7;
	localparam int B_CPD_LO = 8;
	localparam int B_BURST = 10;
	localparam int B_ACK_SYNC = 11;
	localparam int B_BUS_SLOW = 12;
	localparam int B_ARB_SYNC = 13;
	localparam int B_ATTR_OFF = 14;
	localparam int B_TRACE = 15;
	localparam int B_STACK_Y = 16;
	localparam int B_UNDERFLOW = 17;
	localparam int B_OVERFLOW = 18;
	localparam int B_WRAP = 19;
	localparam int B_STACK_EN = 20;
	// Core versus DMA priority encodings
	localparam logic [1:0] CPD_COMPARE = 2'h0;
	localparam logic [1:0] CPD_DMA_HIGH = 2'h1;
	localparam logic [1:0] CPD_EQUAL = 2'h2;
	localparam logic [1:0] CPD_DMA_LOW = 2'h3;
	// Interrupt status bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_UNDERFLOW = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_WRAP = 2;
	localparam int IRQ_STOP_DONE = 3;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	// Stop exit waits in clock cycles
	localparam int STOP_LONG_CYCLES = 131072;
	localparam int STOP_SHORT_CYCLES = 16;
endpackage

// [rtl/sync2.sv]
`timescale 1ns/1ns
// Two flop synchroniser; the first stage feeds only the second
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	// Metastability settles between the two stages
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// [rtl/stop_delay.sv]
`timescale 1ns/1ns
// Counts the stop exit wait and pulses done when it has elapsed
module stop_delay #(
	parameter int LONG_CYCLES = 131072,
	parameter int SHORT_CYCLES = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic short_sel,
	output logic busy,
	output logic done
);
	localparam int CNT_W = $clog2(LONG_CYCLES + 1);
	typedef enum logic {ST_IDLE, ST_WAIT} stop_state_t;
	stop_state_t state_q;
	logic [CNT_W-1:0] cnt_q;

	// Length is fixed at the start; a bit change mid-wait has no effect
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_WAIT;
						busy <= 1'b1;
						cnt_q <= short_sel ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);
					end
				end
				ST_WAIT: begin
					if (cnt_q == '0) begin
						state_q <= ST_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				default: begin
					state_q <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule

// [verification/core_mode_ctrl_tb_top.sv]
`timescale 1ns/1ns
module core_mode_ctrl_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic [3:0] mode_pins = 4'hA;
	logic stack_underflow = 1'b0, stack_overflow = 1'b0, stack_wrap = 1'b0;
	logic stop_exit_req = 1'b0, transfer_ack = 1'b0, bus_grant = 1'b0;
	logic core_req = 1'b0, dma_req = 1'b0;
	logic [1:0] core_priority_field = 2'h0, dma_chan_prio = 2'h0;
	logic [3:0] chip_mode;
	logic ext_bus_off, stop_exit_busy, stop_exit_done, memory_switch_en, dma_wins, cache_burst_en;
	logic transfer_ack_used, bus_grant_used, bus_release_slow, attr_prio_off, addr_trace_en;
	logic stack_ext_y, stack_ext_en, irq;
	int num_errors = 0;
	int n_compared = 0;
	int n;
	logic seen0, seen1;
	localparam int LONG_N = 40;

	// Short long-wait so the 128K path stays testable in a brief run
	core_mode_ctrl #(.STOP_LONG_CYCLES(LONG_N)) dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_pins(mode_pins),
		.stack_underflow(stack_underflow), .stack_overflow(stack_overflow), .stack_wrap(stack_wrap),
		.stop_exit_req(stop_exit_req), .transfer_ack(transfer_ack), .bus_grant(bus_grant),
		.core_req(core_req), .dma_req(dma_req), .core_priority_field(core_priority_field),
		.dma_chan_prio(dma_chan_prio), .chip_mode(chip_mode), .ext_bus_off(ext_bus_off),
		.stop_exit_busy(stop_exit_busy), .stop_exit_done(stop_exit_done),
		.memory_switch_en(memory_switch_en), .dma_wins(dma_wins), .cache_burst_en(cache_burst_en),
		.transfer_ack_used(transfer_ack_used), .bus_grant_used(bus_grant_used),
		.bus_release_slow(bus_release_slow), .attr_prio_off(attr_prio_off),
		.addr_trace_en(addr_trace_en), .stack_ext_y(stack_ext_y), .stack_ext_en(stack_ext_en), .irq(irq));

	// Clock at 50 MHz
	always #10 clk = ~clk;

	task automatic close_out;
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One single AHB transfer; waits on hready, no assumed latency
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, a, d, dummy);
		@(negedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
		chk(hresp, 1'b0);
	endtask

	// Time from an accepted request to the done pulse, in edges
	task automatic stop_run(input logic [31:0] mode, input int exp_n);
		wr(core_mode_pkg::ADDR_MODE, mode);
		@(posedge clk);
		stop_exit_req <= 1'b1;
		@(posedge clk);
		stop_exit_req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			@(negedge clk);
			// Busy must be up from the first edge after the request
			if (n == 1) begin
				chk(stop_exit_busy, 1'b1);
			end
		end while (stop_exit_done !== 1'b1 && n < 300);
		chk(n, exp_n);
		chk(stop_exit_busy, 1'b0);
	endtask

	task automatic stack_pulse(input int which);
		@(posedge clk);
		stack_underflow <= (which == 0);
		stack_overflow <= (which == 1);
		stack_wrap <= (which == 2);
		@(posedge clk);
		{stack_underflow, stack_overflow, stack_wrap} <= 3'h0;
		@(negedge clk);
	endtask

	// Watchdog sized well above the whole sequence
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		// reset value with caught mode pins
		rd_chk(core_mode_pkg::ADDR_MODE, {8'h00, core_mode_pkg::MODE_RESET | 24'h00000A});
		rd_chk(8'h10, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h0000030A);
		// Reserved bits read zero; every control output follows its bit
		wr(core_mode_pkg::ADDR_MODE, 32'hFFFFFFFF);
		rd_chk(core_mode_pkg::ADDR_MODE, {8'h00, core_mode_pkg::MODE_WMASK});
		chk({stack_ext_en, stack_ext_y, addr_trace_en, attr_prio_off, bus_release_slow, cache_burst_en,
			memory_switch_en, ext_bus_off, chip_mode}, 32'h00000FFF);
		wr(core_mode_pkg::ADDR_MODE, 32'h0);
		chk({stack_ext_en, stack_ext_y, addr_trace_en, attr_prio_off, bus_release_slow, cache_burst_en,
			memory_switch_en, ext_bus_off, chip_mode}, 32'h0);
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h0);
		// Short and long stop exit waits
		stop_run(32'h00000040, core_mode_pkg::STOP_SHORT_CYCLES);
		stop_run(32'h00000000, LONG_N);
		// A long wait in progress shows as busy in the state word; it is still running at the status read
		@(posedge clk);
		stop_exit_req <= 1'b1;
		@(posedge clk);
		stop_exit_req <= 1'b0;
		rd_chk(core_mode_pkg::ADDR_STATE, 32'h00000001);
		// Priority codes with both requesting, DMA channel first above core, then equal to it
		@(posedge clk);
		core_req <= 1'b1;
		dma_req <= 1'b1;
		core_priority_field <= 2'h1;
		dma_chan_prio <= 2'h2;
		wr(core_mode_pkg::ADDR_MODE, {22'h0, core_mode_pkg::CPD_COMPARE, 8'h00});
		@(negedge clk);
		chk(dma_wins, 1'b1);
		@(posedge clk);
		dma_chan_prio <= 2'h1;
		repeat (2) @(negedge clk);
		chk(dma_wins, 1'b0);
		wr(core_mode_pkg::ADDR_MODE, {22'h0, core_mode_pkg::CPD_DMA_HIGH, 8'h00});
		@(negedge clk);
		chk(dma_wins, 1'b1);
		wr(core_mode_pkg::ADDR_MODE, {22'h0, core_mode_pkg::CPD_DMA_LOW, 8'h00});
		@(negedge clk);
		chk(dma_wins, 1'b0);
		wr(core_mode_pkg::ADDR_MODE, {22'h0, core_mode_pkg::CPD_EQUAL, 8'h00});
		seen0 = 1'b0;
		seen1 = 1'b0;
		repeat (4) begin
			@(negedge clk);
			seen0 |= (dma_wins === 1'b0);
			seen1 |= (dma_wins === 1'b1);
		end
		chk({seen0, seen1}, 2'h3);
		// Raw versus synchronised acknowledge and grant
		for (int s = 0; s < 2; s++) begin
			wr(core_mode_pkg::ADDR_MODE, s ? 32'h00002800 : 32'h0);
			@(posedge clk);
			transfer_ack <= 1'b1;
			bus_grant <= 1'b1;
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({transfer_ack_used, bus_grant_used}, s ? 2'h0 : 2'h3);
			repeat (2) @(negedge clk);
			chk({transfer_ack_used, bus_grant_used}, 2'h3);
			@(posedge clk);
			transfer_ack <= 1'b0;
			bus_grant <= 1'b0;
			repeat (4) @(negedge clk);
		end
		// Stop done left a status bit; reading clears it
		rd_chk(core_mode_pkg::ADDR_ISTAT, 32'h8);
		stack_pulse(0);
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h00002800);
		wr(core_mode_pkg::ADDR_MODE, 32'h00100000);
		stack_pulse(0);
		stack_pulse(1);
		stack_pulse(2);
		chk(irq, 1'b0);
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h001E0000);
		wr(core_mode_pkg::ADDR_IMASK, 32'h4);
		chk(irq, 1'b1);
		rd_chk(core_mode_pkg::ADDR_ISTAT, 32'h7);
		rd_chk(core_mode_pkg::ADDR_ISTAT, 32'h0);
		@(negedge clk);
		chk(irq, 1'b0);
		// Wrap flag stays until software writes it to zero
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h001E0000);
		wr(core_mode_pkg::ADDR_MODE, 32'h00100000);
		rd_chk(core_mode_pkg::ADDR_MODE, 32'h00100000);
		close_out();
	end
endmodule
